// >>> logic/ssmtx_pkg.sv
// package of constants for the synchronous serial master transmitter
// assumes a 32-bit AHB-Lite register bus and one 50 MHz clock
package ssmtx_pkg;

    // clock rate in hertz
    localparam int unsigned CLK_HZ         = 50_000_000;

    // register byte offsets
    localparam logic [3:0]  OFS_CONTROL    = 4'h0;
    localparam logic [3:0]  OFS_DIVISOR    = 4'h4;
    localparam logic [3:0]  OFS_HOLDING    = 4'h8;
    localparam logic [3:0]  OFS_STATUS     = 4'hC;
    localparam int unsigned ADDR_LSB       = 0;
    localparam int unsigned ADDR_MSB       = 3;

    // control register fields
    localparam int unsigned CTL_SYNC_MODE  = 0;
    localparam int unsigned CTL_CLK_MASTER = 1;
    localparam int unsigned CTL_TX_EN      = 2;
    localparam int unsigned CTL_NINE_BIT   = 3;
    localparam int unsigned CTL_HIGH_RATE  = 4;
    localparam int unsigned CTL_NINTH_BIT  = 5;
    localparam int unsigned CTL_PORT_EN    = 6;
    localparam int unsigned CTL_SINGLE_RX  = 7;
    localparam int unsigned CTL_CONT_RX    = 8;
    localparam int unsigned CTL_WIDTH      = 9;

    // status register fields
    localparam int unsigned STS_HOLD_FULL  = 0;
    localparam int unsigned STS_SHIFT_IDLE = 1;
    localparam int unsigned STS_TX_ACTIVE  = 2;
    localparam int unsigned STS_WIDTH      = 3;

    // widths and reset values
    localparam int unsigned CHAR_BITS      = 8;
    localparam int unsigned SHIFT_BITS     = 9;
    localparam int unsigned DIV_BITS       = 8;
    localparam int unsigned HALF_BITS      = 10;
    localparam int unsigned BIT_CNT_BITS   = 4;
    localparam logic [3:0]  COUNT_EIGHT    = 4'h8;
    localparam logic [3:0]  COUNT_NINE     = 4'h9;
    localparam logic [3:0]  COUNT_ONE      = 4'h1;
    localparam logic [8:0]  CONTROL_RESET  = 9'h000;
    localparam logic [7:0]  DIVISOR_RESET  = 8'h00;
    localparam logic [7:0]  HOLDING_RESET  = 8'h00;

    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    // transmitter states
    typedef enum logic [1:0] {
        SSMTX_IDLE  = 2'b00,
        SSMTX_LOW   = 2'b01,
        SSMTX_HIGH  = 2'b10
    } ssmtx_state_type;

endpackage : ssmtx_pkg

// >>> logic/ssmtx_rate_if.sv
// interface between the transmitter and its bit-rate generator
// assumes both ends share hclk
`timescale 1ns/100ps
interface ssmtx_rate_if;
    import ssmtx_pkg::*;

    logic                run;
    logic [DIV_BITS-1:0] divisor;
    logic                half_tick;

    modport ctrl (output run, output divisor, input half_tick);
    modport gen  (input run, input divisor, output half_tick);

endinterface : ssmtx_rate_if

// >>> logic/ssmtx_rate_gen.sv
// bit-rate generator: one pulse per half bit period
// assumes run falls between characters so each frame starts in phase
`timescale 1ns/100ps
module ssmtx_rate_gen
    import ssmtx_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    ssmtx_rate_if.gen     rate
);

    logic [HALF_BITS-1:0] count_q;
    logic [HALF_BITS-1:0] count_d;
    logic [HALF_BITS-1:0] last_count;
    logic                 tick_q;

    // a bit lasts 4*(n+1) clocks, so a half bit lasts 2*(n+1)
    assign last_count = {1'b0, rate.divisor, 1'b1};

    always_comb begin
        if (!rate.run || count_q == last_count) begin
            count_d = '0;
        end else begin
            count_d = count_q + HALF_BITS'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= rate.run && (count_q == last_count);
        end
    end

    assign rate.half_tick = tick_q;

endmodule : ssmtx_rate_gen

// >>> logic/ssmtx_top.sv
// synchronous serial port, master transmit path, with AHB-Lite registers
// assumes one 50 MHz hclk, single word transfers, pins resolved outside
//
// Contract
// - sync mode bit selects clocked operation
// - master select bit makes us drive clock
// - both receive enables clear means transmit
// - port enable gates the whole port
// - clock pin driver on in master mode
// - data changes leading edge, sampled trailing
// - one clock per data bit only
// - no start or stop bits
// - half duplex, never transmit and receive
// - master transmit enables data and clock drivers
// - holding register write starts transmission
// - new character waits while shifter busy
// - empty shifter takes holding data at once
// - shifting begins right after the transfer
// - data held from leading to leading edge
// - shift register hidden from software
// - transmit enable bit also required
// - ninth bit added when nine-bit selected
// - bit rate is clock over 4(n+1)
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module ssmtx_top
    import ssmtx_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        clock_pin_i,
    output logic             clock_pin_o,
    output logic             clock_pin_oe,
    input  wire logic        data_pin_i,
    output logic             data_pin_o,
    output logic             data_pin_oe
);

    function automatic logic reg_hit(input logic [31:0] addr, input logic [3:0] ofs);
        reg_hit = (addr[ADDR_MSB:ADDR_LSB] == ofs);
    endfunction : reg_hit

    ssmtx_rate_if rate ();

    // software-visible state
    logic [CTL_WIDTH-1:0]    control_q;
    logic [DIV_BITS-1:0]     rate_divisor_q;
    logic [CHAR_BITS-1:0]    tx_holding_reg_q;
    logic                    hold_full_q;

    // hidden shifter state
    logic [SHIFT_BITS-1:0]   tx_shift_reg_q;
    logic [BIT_CNT_BITS-1:0] bits_left_q;
    ssmtx_state_type         state_q;
    ssmtx_state_type         state_d;

    // bus pipeline
    logic                    wr_pend_q;
    logic [31:0]             wr_addr_q;
    logic                    addr_phase;

    // pin and bus output registers
    logic                    clock_q;
    logic                    clock_oe_q;
    logic                    data_q;
    logic                    data_oe_q;
    logic [31:0]             hrdata_q;
    logic                    hreadyout_q;
    logic                    hresp_q;

    // decoded configuration
    logic                    sync_mode_sel;
    logic                    clock_master_sel;
    logic                    transmit_enable;
    logic                    nine_bit_tx_sel;
    logic                    high_rate_sel;
    logic                    ninth_tx_bit;
    logic                    port_enable;
    logic                    single_receive_en;
    logic                    continuous_receive_en;
    logic                    master_cfg;
    logic                    tx_cfg;
    logic                    tx_run;
    logic                    hold_write;
    logic                    load_shifter;
    logic                    last_bit;
    logic [STS_WIDTH-1:0]    status;

    assign sync_mode_sel         = control_q[CTL_SYNC_MODE];
    assign clock_master_sel      = control_q[CTL_CLK_MASTER];
    assign transmit_enable       = control_q[CTL_TX_EN];
    assign nine_bit_tx_sel       = control_q[CTL_NINE_BIT];
    // rate formula ignores this bit in synchronous mode; kept for software only
    assign high_rate_sel         = control_q[CTL_HIGH_RATE];
    assign ninth_tx_bit          = control_q[CTL_NINTH_BIT];
    assign port_enable           = control_q[CTL_PORT_EN];
    assign single_receive_en     = control_q[CTL_SINGLE_RX];
    assign continuous_receive_en = control_q[CTL_CONT_RX];

    assign master_cfg = sync_mode_sel && clock_master_sel && port_enable;

    assign tx_cfg = master_cfg && transmit_enable && !single_receive_en && !continuous_receive_en;

    assign tx_run = tx_cfg;

    // AHB-Lite slave
    assign addr_phase = hsel && htrans[1] && hready;

    assign status = {(state_q != SSMTX_IDLE), (state_q == SSMTX_IDLE), hold_full_q};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_q <= haddr;
            end
        end
    end

    assign hold_write = wr_pend_q && reg_hit(wr_addr_q, OFS_HOLDING);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (addr_phase && !hwrite) begin
            if (reg_hit(haddr, OFS_CONTROL)) begin
                hrdata_q <= {{(32-CTL_WIDTH){1'b0}}, control_q};
            end else if (reg_hit(haddr, OFS_DIVISOR)) begin
                hrdata_q <= {{(32-DIV_BITS){1'b0}}, rate_divisor_q};
            end else if (reg_hit(haddr, OFS_HOLDING)) begin
                hrdata_q <= {{(32-CHAR_BITS){1'b0}}, tx_holding_reg_q};
            end else if (reg_hit(haddr, OFS_STATUS)) begin
                hrdata_q <= {{(32-STS_WIDTH){1'b0}}, status};
            end else begin
                hrdata_q <= '0;
            end
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= HRESP_OKAY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_q <= CONTROL_RESET;
        end else if (wr_pend_q && reg_hit(wr_addr_q, OFS_CONTROL)) begin
            control_q <= hwdata[CTL_WIDTH-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_divisor_q <= DIVISOR_RESET;
        end else if (wr_pend_q && reg_hit(wr_addr_q, OFS_DIVISOR)) begin
            rate_divisor_q <= hwdata[DIV_BITS-1:0];
        end
    end

    // holding register
    // write arms a transmission
    // a full holding register ignores writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_holding_reg_q <= HOLDING_RESET;
        end else if (hold_write && !hold_full_q) begin
            tx_holding_reg_q <= hwdata[CHAR_BITS-1:0];
        end
    end

    // empty shifter takes character at once
    assign load_shifter = tx_run && hold_full_q && (state_q == SSMTX_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_full_q <= 1'b0;
        end else if (!port_enable) begin
            hold_full_q <= 1'b0;
        end else if (hold_write && !hold_full_q) begin
            hold_full_q <= 1'b1;
        end else if (load_shifter) begin
            hold_full_q <= 1'b0;
        end
    end

    // shifter and clock
    assign rate.run     = tx_run && (state_q != SSMTX_IDLE);
    assign rate.divisor = rate_divisor_q;

    assign last_bit = (bits_left_q == COUNT_ONE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            SSMTX_IDLE: begin
                if (load_shifter) begin
                    state_d = SSMTX_LOW;
                end
            end
            SSMTX_LOW: begin
                if (rate.half_tick) begin
                    state_d = SSMTX_HIGH;
                end
            end
            SSMTX_HIGH: begin
                if (rate.half_tick) begin
                    state_d = last_bit ? SSMTX_IDLE : SSMTX_LOW;
                end
            end
            default: begin
                state_d = SSMTX_IDLE;
            end
        endcase
        if (!tx_run) begin
            state_d = SSMTX_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= SSMTX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ninth bit on top when selected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_shift_reg_q <= '0;
            bits_left_q    <= '0;
        end else if (!tx_run) begin
            tx_shift_reg_q <= '0;
            bits_left_q    <= '0;
        end else if (load_shifter) begin
            tx_shift_reg_q <= {ninth_tx_bit, tx_holding_reg_q};
            bits_left_q    <= nine_bit_tx_sel ? COUNT_NINE : COUNT_EIGHT;
        end else if (state_q == SSMTX_LOW && rate.half_tick) begin
            tx_shift_reg_q <= {1'b0, tx_shift_reg_q[SHIFT_BITS-1:1]};
        end else if (state_q == SSMTX_HIGH && rate.half_tick) begin
            bits_left_q    <= bits_left_q - COUNT_ONE;
        end
    end

    // rise with data change, fall to sample
    // data moves on rising edge, and clears to 0 when tx_run drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_q <= 1'b0;
            data_q  <= 1'b0;
        end else if (!tx_run) begin
            clock_q <= 1'b0;
            data_q  <= 1'b0;
        end else if (state_q == SSMTX_LOW && rate.half_tick) begin
            clock_q <= 1'b1;
            data_q  <= tx_shift_reg_q[0];
        end else if (state_q == SSMTX_HIGH && rate.half_tick) begin
            clock_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_oe_q <= 1'b0;
            data_oe_q  <= 1'b0;
        end else begin
            clock_oe_q <= master_cfg;
            data_oe_q  <= tx_cfg;
        end
    end

    ssmtx_rate_gen u_rate_gen (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rate    (rate)
    );

    assign hrdata       = hrdata_q;
    assign hreadyout    = hreadyout_q;
    assign hresp        = hresp_q;
    assign clock_pin_o  = clock_q;
    assign clock_pin_oe = clock_oe_q;
    assign data_pin_o   = data_q;
    assign data_pin_oe  = data_oe_q;

endmodule : ssmtx_top

// >>> test/ssmtx_checker.sv
// assertions on the pins and bus of the serial master transmitter top
// assumes hready follows hreadyout and the divisor is stable within a frame
`timescale 1ns/100ps
module ssmtx_checker
    import ssmtx_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        clock_pin_o,
    input wire logic        clock_pin_oe,
    input wire logic        data_pin_o,
    input wire logic        data_pin_oe
);
    logic                wr_div_q;
    logic [DIV_BITS-1:0] div_q;
    logic [9:0]          high_cnt_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // shadow of the divisor register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_div_q <= 1'b0;
            div_q    <= DIVISOR_RESET;
        end else begin
            if (hready) begin
                wr_div_q <= hsel && htrans[1] && hwrite && (haddr[3:0] == OFS_DIVISOR);
            end
            if (wr_div_q) begin
                div_q <= hwdata[DIV_BITS-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_cnt_q <= 10'h000;
        end else begin
            high_cnt_q <= clock_pin_o ? high_cnt_q + 10'h001 : 10'h000;
        end
    end

    clk_driver_a: assert property (clock_pin_o |-> clock_pin_oe)
        else $error("clock toggles with its driver off");
    data_driver_a: assert property (data_pin_oe |-> clock_pin_oe)
        else $error("data driver on without clock driver");
    port_off_a: assert property (!clock_pin_oe |-> !clock_pin_o && !data_pin_oe && !data_pin_o)
        else $error("pins active while port is off");
    data_hold_a: assert property (data_pin_oe && $past(data_pin_oe) && !$rose(clock_pin_o) |-> $stable(data_pin_o))
        else $error("data changed away from a leading edge");
    trail_stable_a: assert property ($fell(clock_pin_o) && data_pin_oe |-> $stable(data_pin_o))
        else $error("data moved on the trailing edge");
    half_bit_a: assert property ($fell(clock_pin_o) && data_pin_oe |-> high_cnt_q == 2 * (div_q + 1))
        else $error("clock high time differs from divisor");
    rest_low_a: assert property ($fell(clock_pin_o) && data_pin_oe |-> !clock_pin_o [*2])
        else $error("clock low phase too short");
    bus_okay_a: assert property (hreadyout && (hresp == HRESP_OKAY))
        else $error("bus slave stalled or errored");

    cover property ($rose(clock_pin_o) && data_pin_oe);
    cover property ($fell(clock_pin_oe));
    cover property ($fell(clock_pin_o) && div_q != DIVISOR_RESET);
endmodule : ssmtx_checker

bind ssmtx_top ssmtx_checker u_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe), .data_pin_o(data_pin_o),
    .data_pin_oe(data_pin_oe));

// >>> test/ssmtx_slave_model.sv
// behavioural slave that shifts in the master's serial data
// assumes the clock idles low and the data line is pulled up when released
`timescale 1ns/100ps
module ssmtx_slave_model (
    input  wire logic       clock_line,
    input  wire logic       data_line,
    input  wire logic       clear,
    output logic      [8:0] got_q,
    output logic      [4:0] bits_q
);
    always @(negedge clock_line or posedge clear) begin
        if (clear) begin
            got_q  <= 9'h000;
            bits_q <= 5'h00;
        end else begin
            got_q  <= {data_line, got_q[8:1]};
            bits_q <= bits_q + 5'h01;
        end
    end
endmodule : ssmtx_slave_model

// >>> test/testbench.sv
// self-checking bench for the serial master transmitter
// assumes zero wait state bus and a pulled-up data line
`timescale 1ns/100ps
module testbench;
    import ssmtx_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        clear = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, ck_o, ck_oe, dt_o, dt_oe;
    logic [8:0]  got_q;
    logic [4:0]  bits_q;
    wire         data_line = dt_oe ? dt_o : 1'b1;
    wire         clock_line = ck_oe ? ck_o : 1'b0;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    ssmtx_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .clock_pin_i(clock_line), .clock_pin_o(ck_o),
        .clock_pin_oe(ck_oe), .data_pin_i(data_line), .data_pin_o(dt_o), .data_pin_oe(dt_oe));
    ssmtx_slave_model slave (.clock_line(clock_line), .data_line(data_line), .clear(clear),
        .got_q(got_q), .bits_q(bits_q));

    always #10 hclk = ~hclk;

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {28'h0000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic restart();
        clear <= 1'b1;
        @(posedge hclk);
        clear <= 1'b0;
    endtask : restart

    task automatic t_reset();
        logic [31:0] rd;
        check("pins", {ck_o, ck_oe, dt_o, dt_oe}, 32'h0);
        check("bus okay", {hreadyout, hresp}, 32'h2);
        bus(OFS_CONTROL, 1'b0, 32'h0, rd);
        check("control", rd, 32'h0);
        bus(OFS_STATUS, 1'b0, 32'h0, rd);
        check("status", rd, 32'h2);
    endtask : t_reset

    task automatic t_config();
        logic [31:0] rd;
        logic [8:0]  bad [6] = '{9'h046, 9'h045, 9'h043, 9'h007, 9'h0C7, 9'h147};
        for (int i = 0; i < 6; i++) begin
            restart();
            bus(OFS_CONTROL, 1'b1, {23'h0, bad[i]}, rd);
            bus(OFS_HOLDING, 1'b1, 32'hA5, rd);
            repeat (40) @(posedge hclk);
            check("clock oe", ck_oe, bad[i][0] & bad[i][1] & bad[i][6]);
            check("data oe", dt_oe, 1'b0);
            check("bits", bits_q, 32'h0);
            bus(OFS_CONTROL, 1'b1, 32'h0, rd);
        end
    endtask : t_config

    task automatic t_send(input logic [7:0] dv, input logic [8:0] ctl, input logic [7:0] ch);
        int          n;
        logic [31:0] rd;
        restart();
        bus(OFS_DIVISOR, 1'b1, {24'h0, dv}, rd);
        bus(OFS_CONTROL, 1'b1, {23'h0, ctl}, rd);
        bus(OFS_HOLDING, 1'b1, {24'h0, ch}, rd);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (ck_o !== 1'b1);
        check("start delay", n, 2 * (dv + 1) + 2);
        check("first bit", dt_o, ch[0]);
        check("data oe", dt_oe, 1'b1);
        wait (bits_q == (ctl[3] ? 9 : 8));
        repeat (8 * (dv + 1) + 8) @(posedge hclk);
        check("bit count", bits_q, ctl[3] ? 9 : 8);
        check("char", ctl[3] ? got_q : got_q[8:1], ctl[3] ? {ctl[5], ch} : ch);
    endtask : t_send

    task automatic t_back();
        logic [31:0] rd;
        restart();
        bus(OFS_DIVISOR, 1'b1, 32'h1, rd);
        bus(OFS_CONTROL, 1'b1, 32'h47, rd);
        bus(OFS_HOLDING, 1'b1, 32'h3C, rd);
        bus(OFS_HOLDING, 1'b1, 32'hC3, rd);
        bus(OFS_STATUS, 1'b0, 32'h0, rd);
        check("status busy", rd[2:0], 3'h5);
        wait (bits_q == 8);
        check("first char", got_q[8:1], 8'h3C);
        wait (bits_q == 16);
        check("second char", got_q[8:1], 8'hC3);
    endtask : t_back

    task automatic t_abort();
        logic [31:0] rd;
        restart();
        bus(OFS_HOLDING, 1'b1, 32'hFF, rd);
        wait (bits_q == 3);
        bus(OFS_CONTROL, 1'b1, 32'h07, rd);
        repeat (2) @(posedge hclk);
        #1;
        check("abort pins", {ck_o, ck_oe, dt_o, dt_oe}, 32'h0);
        bus(OFS_STATUS, 1'b0, 32'h0, rd);
        check("abort status", rd[2:0], 3'h2);
    endtask : t_abort

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_config();
        t_send(8'h00, 9'h047, 8'h96);
        t_send(8'h03, 9'h07F, 8'h5A);
        t_back();
        t_abort();
        summarize();
    end
endmodule : testbench
